// >>> include/crf_pkg.sv
// Constants, field layout and types of the receive filter block.
// Assumes one clock domain and a 32-bit Avalon-MM register bus.
`default_nettype none
package crf_pkg;
   // ----------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int STD_W = 11;
   localparam int EXT_W = 2;
   localparam logic [ADDR_W-1:0] OFS_FILT = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;
   // ----------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------
   localparam int STD_HI = 15;
   localparam int STD_LO = 5;
   localparam int EXT_EN_BIT = 3;
   localparam int EXT_HI = 1;
   localparam int EXT_LO = 0;
   localparam int STAT_HIT_BIT = 0;
   localparam int STAT_SEEN_BIT = 1;
   // Bits 4 and 2 are not implemented in either layout.
   localparam logic [REG_W-1:0] IMPL_BITS = 16'hFFEB;
   // ----------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------
   localparam logic [REG_W-1:0] FILT_RST = 16'h0000;
   localparam logic [REG_W-1:0] MASK_RST = 16'hFFE3;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
   // ----------------------------------------------------------
   // Bus handshake states
   // ----------------------------------------------------------
   typedef enum logic [0:0]
   {
      CRF_BUS_IDLE = 1'h0,
      CRF_BUS_ACK = 1'h1
   } crf_bus_t;
endpackage
`default_nettype wire

// >>> hw/crf_rx_filter.sv
// Standard-identifier acceptance filter with its mask and status registers.
// Assumes a synchronous Avalon-MM master and one message identifier per strobe.
`timescale 1ns/100ps
`default_nettype none
module crf_rx_filter
(
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic [crf_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [crf_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [crf_pkg::DATA_W-1:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   input wire logic I_MSG_VALID,
   input wire logic [crf_pkg::STD_W-1:0] I_MSG_STD_IDENT,
   input wire logic [crf_pkg::EXT_W-1:0] I_MSG_EXT_IDENT_HI,
   input wire logic I_MSG_IS_EXT,
   output logic O_FILTER_HIT,
   output logic O_HIT_VALID
);

   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   crf_pkg::crf_bus_t st_r;
   crf_pkg::crf_bus_t st_nxt;
   logic wait_r;
   logic wait_nxt;
   logic [crf_pkg::DATA_W-1:0] rdata_r;
   logic [crf_pkg::DATA_W-1:0] rdata_nxt;
   logic [crf_pkg::REG_W-1:0] filt_r;
   logic [crf_pkg::REG_W-1:0] filt_nxt;
   logic [crf_pkg::REG_W-1:0] mask_r;
   logic [crf_pkg::REG_W-1:0] mask_nxt;
   logic hit_r;
   logic hit_nxt;
   logic hvalid_r;
   logic hvalid_nxt;
   logic seen_r;
   logic seen_nxt;
   logic [crf_pkg::REG_W-1:0] wmask;
   logic [crf_pkg::REG_W-1:0] wval;
   logic [crf_pkg::STD_W-1:0] std_miss;
   logic [crf_pkg::EXT_W-1:0] ext_miss;
   logic std_ok;
   logic ext_ok;
   logic type_ok;
   logic hit_now;
   logic wr_done;

   // ----------------------------------------------------------
   // Identifier compare
   // ----------------------------------------------------------
   // A bit misses only where the mask enables it and the values differ.
   for (genvar g = 0; g < crf_pkg::STD_W; g++)
   begin : g_std
      assign std_miss[g] = mask_r[crf_pkg::STD_LO+g]
         & (I_MSG_STD_IDENT[g] ^ filt_r[crf_pkg::STD_LO+g]);
   end
   for (genvar e = 0; e < crf_pkg::EXT_W; e++)
   begin : g_ext
      assign ext_miss[e] = mask_r[crf_pkg::EXT_LO+e]
         & (I_MSG_EXT_IDENT_HI[e] ^ filt_r[crf_pkg::EXT_LO+e]);
   end

   always_comb
   begin
      std_ok = ~|std_miss;
      // Standard frames carry no bits 17..16, so they cannot miss there.
      ext_ok = ~I_MSG_IS_EXT | ~|ext_miss;
      if (mask_r[crf_pkg::EXT_EN_BIT])
      begin
         type_ok = filt_r[crf_pkg::EXT_EN_BIT] == I_MSG_IS_EXT;
      end
      else
      begin
         type_ok = 1'b1;
      end
      hit_now = std_ok & ext_ok & type_ok;
      hvalid_nxt = I_MSG_VALID;
      hit_nxt = hit_r;
      seen_nxt = seen_r;
      if (I_MSG_VALID)
      begin
         hit_nxt = hit_now;
         seen_nxt = 1'b1;
      end
   end

   // ----------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------
   // One wait cycle on every access keeps read data straight from a flop.
   always_comb
   begin
      wr_done = I_AVS_WRITE & ~wait_r;
      wmask = {{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}}
         & crf_pkg::IMPL_BITS;
      wval = I_AVS_WRITEDATA[crf_pkg::REG_W-1:0] & wmask;
      filt_nxt = filt_r;
      mask_nxt = mask_r;
      if (wr_done && I_AVS_ADDRESS == crf_pkg::OFS_FILT)
      begin
         filt_nxt = (filt_r & ~wmask) | wval;
      end
      else if (wr_done && I_AVS_ADDRESS == crf_pkg::OFS_MASK)
      begin
         mask_nxt = (mask_r & ~wmask) | wval;
      end
      st_nxt = st_r;
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      case (st_r)
         crf_pkg::CRF_BUS_IDLE:
         begin
            if (I_AVS_READ || I_AVS_WRITE)
            begin
               st_nxt = crf_pkg::CRF_BUS_ACK;
               wait_nxt = 1'b0;
               rdata_nxt = crf_pkg::RDATA_RST;
               if (I_AVS_ADDRESS == crf_pkg::OFS_FILT)
               begin
                  rdata_nxt[crf_pkg::REG_W-1:0] = filt_r;
               end
               else if (I_AVS_ADDRESS == crf_pkg::OFS_MASK)
               begin
                  rdata_nxt[crf_pkg::REG_W-1:0] = mask_r;
               end
               else if (I_AVS_ADDRESS == crf_pkg::OFS_STAT)
               begin
                  rdata_nxt[crf_pkg::STAT_HIT_BIT] = hit_r;
                  rdata_nxt[crf_pkg::STAT_SEEN_BIT] = seen_r;
               end
            end
         end
         crf_pkg::CRF_BUS_ACK:
         begin
            st_nxt = crf_pkg::CRF_BUS_IDLE;
         end
         default:
         begin
            st_nxt = crf_pkg::CRF_BUS_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------
   // Flip-flops
   // ----------------------------------------------------------
   // The stored identifier is undefined in the silicon; zero keeps sims clean.
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         st_r <= crf_pkg::CRF_BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= crf_pkg::RDATA_RST;
         filt_r <= crf_pkg::FILT_RST;
         mask_r <= crf_pkg::MASK_RST;
         hit_r <= 1'b0;
         hvalid_r <= 1'b0;
         seen_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         filt_r <= filt_nxt;
         mask_r <= mask_nxt;
         hit_r <= hit_nxt;
         hvalid_r <= hvalid_nxt;
         seen_r <= seen_nxt;
      end
   end

   assign O_AVS_READDATA = rdata_r;
   assign O_AVS_WAITREQUEST = wait_r;
   assign O_FILTER_HIT = hit_r;
   assign O_HIT_VALID = hvalid_r;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RST);
   // Results are judged one cycle after the message, where the registered hit stands.
   // Checking there rather than on the comparators keeps the output flops covered too.

   a_std_store: assert property (
      wr_done && I_AVS_ADDRESS == crf_pkg::OFS_FILT && (&I_AVS_BYTEENABLE[1:0])
      |=> filt_r[crf_pkg::STD_HI:crf_pkg::STD_LO]
         == $past(I_AVS_WRITEDATA[crf_pkg::STD_HI:crf_pkg::STD_LO]))
      else $error("Standard identifier field did not take the write.");

   a_filt_readback: assert property (
      st_r == crf_pkg::CRF_BUS_IDLE && I_AVS_READ
      && I_AVS_ADDRESS == crf_pkg::OFS_FILT
      |=> !O_AVS_WAITREQUEST
         && O_AVS_READDATA[crf_pkg::REG_W-1:0] == $past(filt_r)
      ##1 O_AVS_WAITREQUEST)
      else $error("Filter read did not return the stored value in one cycle.");

   a_unimpl_zero: assert property (
      !O_AVS_WAITREQUEST && $past(I_AVS_ADDRESS) == crf_pkg::OFS_FILT
      |-> (O_AVS_READDATA[crf_pkg::REG_W-1:0] & ~crf_pkg::IMPL_BITS) == 16'h0000)
      else $error("Unimplemented filter bit read back as one.");

   a_std_mismatch: assert property (
      I_MSG_VALID && (I_MSG_STD_IDENT[0] != filt_r[crf_pkg::STD_LO])
      && mask_r[crf_pkg::STD_LO]
      |=> O_HIT_VALID && !O_FILTER_HIT)
      else $error("Hit reported despite a compared standard bit differing.");

   a_ext_only: assert property (
      I_MSG_VALID && mask_r[crf_pkg::EXT_EN_BIT]
      && filt_r[crf_pkg::EXT_EN_BIT] && !I_MSG_IS_EXT
      |=> !O_FILTER_HIT)
      else $error("Standard frame accepted while only extended frames allowed.");

   a_std_only: assert property (
      I_MSG_VALID && mask_r[crf_pkg::EXT_EN_BIT]
      && !filt_r[crf_pkg::EXT_EN_BIT] && I_MSG_IS_EXT
      |=> !O_FILTER_HIT)
      else $error("Extended frame accepted while only standard frames allowed.");

   a_type_ignored: assert property (
      I_MSG_VALID && !mask_r[crf_pkg::EXT_EN_BIT] && std_ok && ext_ok
      |=> O_FILTER_HIT)
      else $error("Frame format rejected with the type check off.");

   a_ext_mismatch: assert property (
      I_MSG_VALID && I_MSG_IS_EXT && mask_r[crf_pkg::EXT_HI]
      && (I_MSG_EXT_IDENT_HI[1] != filt_r[crf_pkg::EXT_HI])
      |=> !O_FILTER_HIT)
      else $error("Hit reported despite extended bit 17 differing.");

   a_mask_dontcare: assert property (
      I_MSG_VALID && !mask_r[crf_pkg::EXT_EN_BIT]
      && (mask_r & crf_pkg::IMPL_BITS) == 16'h0000
      |=> O_HIT_VALID && O_FILTER_HIT)
      else $error("Miss reported with every compare masked out.");

   a_std_match: assert property (
      I_MSG_VALID && !I_MSG_IS_EXT && !mask_r[crf_pkg::EXT_EN_BIT]
      && I_MSG_STD_IDENT == filt_r[crf_pkg::STD_HI:crf_pkg::STD_LO]
      |=> O_HIT_VALID && O_FILTER_HIT)
      else $error("Miss reported for a standard frame equal to the filter.");

   a_std_accept: assert property (
      I_MSG_VALID && !I_MSG_IS_EXT && mask_r[crf_pkg::EXT_EN_BIT]
      && !filt_r[crf_pkg::EXT_EN_BIT]
      && I_MSG_STD_IDENT == filt_r[crf_pkg::STD_HI:crf_pkg::STD_LO]
      |=> O_FILTER_HIT)
      else $error("Matching standard frame rejected while standard frames allowed.");

   a_ext_accept: assert property (
      I_MSG_VALID && I_MSG_IS_EXT && mask_r[crf_pkg::EXT_EN_BIT]
      && filt_r[crf_pkg::EXT_EN_BIT]
      && I_MSG_STD_IDENT == filt_r[crf_pkg::STD_HI:crf_pkg::STD_LO]
      && I_MSG_EXT_IDENT_HI == filt_r[crf_pkg::EXT_HI:crf_pkg::EXT_LO]
      |=> O_FILTER_HIT)
      else $error("Matching extended frame rejected while extended frames allowed.");

   a_unimpl_store: assert property (
      (filt_r & ~crf_pkg::IMPL_BITS) == 16'h0000
      && (mask_r & ~crf_pkg::IMPL_BITS) == 16'h0000)
      else $error("Unimplemented register bit was stored as one.");

   a_lane_keep: assert property (
      wr_done && I_AVS_ADDRESS == crf_pkg::OFS_FILT && !I_AVS_BYTEENABLE[1]
      |=> $stable(filt_r[crf_pkg::REG_W-1:crf_pkg::REG_W/2]))
      else $error("Filter upper byte changed with its byte lane disabled.");

   a_mask_store: assert property (
      wr_done && I_AVS_ADDRESS == crf_pkg::OFS_MASK && (&I_AVS_BYTEENABLE[1:0])
      |=> mask_r == ($past(I_AVS_WRITEDATA[crf_pkg::REG_W-1:0]) & crf_pkg::IMPL_BITS))
      else $error("Mask register did not take the write.");

   a_hit_hold: assert property (
      !I_MSG_VALID |=> !O_HIT_VALID && $stable(O_FILTER_HIT))
      else $error("Hit result changed without an incoming message.");

   c_hit_ext: cover property (I_MSG_VALID && I_MSG_IS_EXT ##1 O_FILTER_HIT);
   c_hit_std: cover property (I_MSG_VALID && !I_MSG_IS_EXT ##1 O_FILTER_HIT);
   c_miss: cover property (I_MSG_VALID ##1 !O_FILTER_HIT);
   c_write: cover property (wr_done && I_AVS_ADDRESS == crf_pkg::OFS_FILT);
   c_mask_off: cover property (I_MSG_VALID && (mask_r & crf_pkg::IMPL_BITS) == 16'h0000);

endmodule
`default_nettype wire

// >>> testbench/crf_msg_src.sv
// Model of the bus side: hands the filter one received identifier per call.
// Assumes the bench calls send from a single process.
`timescale 1ns/100ps
`default_nettype none
module crf_msg_src
(
   input wire logic i_clk,
   output logic o_valid,
   output logic [crf_pkg::STD_W-1:0] o_std,
   output logic [crf_pkg::EXT_W-1:0] o_ext,
   output logic o_is_ext
);
   // --------------------------------------------------------
   // Frame delivery
   // --------------------------------------------------------
   initial
   begin
      o_valid = 1'b0;
      o_std = 11'h000;
      o_ext = 2'h0;
      o_is_ext = 1'b0;
   end
   task automatic send(input logic [10:0] s, input logic [1:0] e, input logic x);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_std <= s;
      o_ext <= e;
      o_is_ext <= x;
      @(posedge i_clk);
      o_valid <= 1'b0;
      // Idle lines carry the inverse, so a stale copy is never mistaken for data.
      o_std <= ~s;
      o_ext <= ~e;
      o_is_ext <= ~x;
   endtask
endmodule
`default_nettype wire

// >>> testbench/crf_rx_filter_tb.sv
// Self-checking bench of the receive filter and its register bus.
// Assumes the register bus answers within twenty cycles; a longer wait is a failure.
`timescale 1ns/100ps
`default_nettype none
module crf_rx_filter_tb;
   logic clk;
   logic rst;
   logic [3:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [31:0] rdata;
   logic waitreq;
   logic mv;
   logic [10:0] ms;
   logic [1:0] me;
   logic mx;
   logic hit;
   logic hv;
   int n_mismatch = 0;
   int comparisons = 0;
   crf_rx_filter uut (.I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
      .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
      .I_MSG_VALID(mv), .I_MSG_STD_IDENT(ms), .I_MSG_EXT_IDENT_HI(me),
      .I_MSG_IS_EXT(mx), .O_FILTER_HIT(hit), .O_HIT_VALID(hv));
   crf_msg_src src (.i_clk(clk), .o_valid(mv), .o_std(ms), .o_ext(me), .o_is_ext(mx));
   // --------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic conclude();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (n > 20)
         begin
            n_mismatch++;
            conclude();
         end
      end
      while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d, input logic [3:0] b);
      logic [31:0] q;
      bus(1'b1, a, {16'hA5A5, d}, b, q);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, 4'h0, q);
   endtask
   task automatic msg(input logic [10:0] s, input logic [1:0] e, input logic x,
                      input logic exp);
      src.send(s, e, x);
      #1;
      chk({30'h0, hv, hit}, {30'h0, 1'b1, exp});
   endtask
   // --------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------
   task automatic reg_map();
      logic [31:0] q;
      rd_reg(crf_pkg::OFS_MASK, q);
      chk(q, 32'h0000_FFE3);
      rd_reg(4'hC, q);
      chk(q, 32'h0000_0000);
      wr_reg(crf_pkg::OFS_FILT, 16'hFFFF, 4'hF);
      rd_reg(crf_pkg::OFS_FILT, q);
      chk(q, 32'h0000_FFEB);
      wr_reg(crf_pkg::OFS_FILT, 16'h0000, 4'h1);
      rd_reg(crf_pkg::OFS_FILT, q);
      chk(q, 32'h0000_FF00);
   endtask
   task automatic match_typed();
      wr_reg(crf_pkg::OFS_MASK, 16'hFFEB, 4'h3);
      wr_reg(crf_pkg::OFS_FILT, 16'hA5A2, 4'h3);
      msg(11'h52D, 2'h1, 1'b0, 1'b1);
      msg(11'h52C, 2'h2, 1'b0, 1'b0);
      msg(11'h52D, 2'h2, 1'b1, 1'b0);
      wr_reg(crf_pkg::OFS_FILT, 16'hA5AA, 4'h1);
      msg(11'h52D, 2'h2, 1'b1, 1'b1);
      msg(11'h52D, 2'h3, 1'b1, 1'b0);
      msg(11'h52D, 2'h2, 1'b0, 1'b0);
   endtask
   task automatic match_free();
      logic [31:0] q;
      wr_reg(crf_pkg::OFS_MASK, 16'hFFC3, 4'h3);
      msg(11'h52C, 2'h0, 1'b0, 1'b1);
      msg(11'h52D, 2'h2, 1'b1, 1'b1);
      rd_reg(crf_pkg::OFS_STAT, q);
      chk(q, 32'h0000_0003);
   endtask
   task automatic reset_masked();
      logic [31:0] q;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk({30'h0, hv, hit}, 32'h0000_0000);
      rd_reg(crf_pkg::OFS_FILT, q);
      chk(q, 32'h0000_0000);
      rd_reg(crf_pkg::OFS_STAT, q);
      chk(q, 32'h0000_0000);
      wr_reg(crf_pkg::OFS_MASK, 16'h0000, 4'h3);
      msg(11'h7FF, 2'h3, 1'b1, 1'b1);
      msg(11'h000, 2'h0, 1'b0, 1'b1);
   endtask
   initial
   begin
      rst = 1'b1;
      addr = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0000_0000;
      be = 4'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      reg_map();
      match_typed();
      match_free();
      reset_masked();
      conclude();
   end
endmodule
`default_nettype wire
